// ---- clash_consts.svh ----
// timing, geometry and reset constants for the channel clash monitor
`ifndef CLASH_CONSTS_SVH
`define CLASH_CONSTS_SVH

// channel geometry
`define CLASH_NUM_CH          16
`define CLASH_NUM_PAIRS       120

// recognition window: must not trip under 200 ms, must trip over 500 ms
`define CLASH_MIN_MS          200
`define CLASH_MAX_MS          500
// chosen qualification point inside the window
`define CLASH_QUAL_MS         350

// clock and tick divider
`define CLASH_CLK_HZ          200000000
`define CLASH_TICK_HZ         1000
`define CLASH_TICK_DIV        (`CLASH_CLK_HZ / `CLASH_TICK_HZ)

// reset values
`define CLASH_CNT_RST         16'h0000
`define CLASH_DIV_RST         18'h0_0000

`endif

// ---- clash_monitor_properties.sv ----
// port checker for the channel clash monitor
`timescale 1ns/1ps
module clash_monitor_properties #(
  parameter int NUM_CH     = 16,
  parameter int TICK_DIV   = 10,
  parameter int QUAL_TICKS = 350
) (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     rstn,
  // field, map and clears
  input wire logic [NUM_CH-1:0]        green_in,
  input wire logic [NUM_CH-1:0]        yellow_in,
  input wire logic [NUM_CH*NUM_CH-1:0] compat_map,
  input wire logic                     panel_reset_n,
  input wire logic                     ext_reset_n,
  // fault outputs
  input wire logic                     clash_fault_q,
  input wire logic                     relay_ok_q,
  input wire logic                     halt_req_q,
  input wire logic [NUM_CH-1:0]        fault_ch_q
);
  // ======
  // helpers
  logic        clash;
  logic [31:0] run_q, peak_q, age_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // raw clash straight off the pins, ahead of the design's syncing
  always_comb begin
    clash = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      for (int j = 0; j < NUM_CH; j++)
        if (i != j && (green_in[i] | yellow_in[i]) && (green_in[j] | yellow_in[j])
            && !compat_map[i*NUM_CH+j] && !compat_map[j*NUM_CH+i]) clash = 1'b1;
  end
  // current run length and length of the latest run, kept after it ends
  always_ff @(posedge ref_clk) begin
    run_q  <= (!rstn || !clash) ? 32'h0000_0000 : run_q + 32'h0000_0001;
    peak_q <= !rstn ? 32'h0000_0000 : (clash ? run_q + 32'h0000_0001 : peak_q);
  end
  // cycles since either clear was last low, saturating
  always_ff @(posedge ref_clk) begin
    age_q <= (!rstn || !panel_reset_n || !ext_reset_n) ? 32'h0000_0000 : age_q + {31'h0, age_q < 32'h0000_00ff};
  end
  // ======
  // properties
  property p_halt; halt_req_q == clash_fault_q; endproperty
  a_halt: assert property (p_halt) else $error("halt request differs from fault");
  property p_relay; clash_fault_q |-> !relay_ok_q; endproperty
  a_relay: assert property (p_relay) else $error("relay energised in fault");
  property p_relay_up; $past(rstn) && $past(rstn, 2) && $past(rstn, 3) && !clash_fault_q |-> relay_ok_q; endproperty
  a_relay_up: assert property (p_relay_up) else $error("relay off without fault");
  property p_latch; age_q > 32'h0000_0008 && $past(rstn) |-> !$fell(clash_fault_q); endproperty
  a_latch: assert property (p_latch) else $error("fault dropped without a clear");
  property p_min; $rose(clash_fault_q) |-> peak_q >= 200 * TICK_DIV; endproperty
  a_min: assert property (p_min) else $error("fault on a short or permitted clash");
  property p_max; run_q == (QUAL_TICKS + 1) * TICK_DIV + 20 |-> clash_fault_q; endproperty
  a_max: assert property (p_max) else $error("long clash not declared");
  property p_rst; disable iff (1'b0) !rstn |=> !clash_fault_q && !relay_ok_q && !halt_req_q && fault_ch_q == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_chans; clash_fault_q |-> fault_ch_q != '0; endproperty
  a_chans: assert property (p_chans) else $error("fault without channels");
  property p_hold; clash_fault_q && $past(clash_fault_q) |-> $stable(fault_ch_q); endproperty
  a_hold: assert property (p_hold) else $error("fault channels changed while latched");
  c_trip: cover property ($rose(clash_fault_q));
  c_clear: cover property ($fell(clash_fault_q));
  c_short: cover property ($fell(clash) && peak_q > 100 * TICK_DIV && !clash_fault_q);
endmodule
bind signal_channel_clash_monitor clash_monitor_properties #(.NUM_CH(NUM_CH), .TICK_DIV(TICK_DIV),
  .QUAL_TICKS(QUAL_TICKS)) i_props (.ref_clk(ref_clk), .rstn(rstn), .green_in(green_in), .yellow_in(yellow_in),
  .compat_map(compat_map), .panel_reset_n(panel_reset_n), .ext_reset_n(ext_reset_n), .clash_fault_q(clash_fault_q),
  .relay_ok_q(relay_ok_q), .halt_req_q(halt_req_q), .fault_ch_q(fault_ch_q));

// ---- clash_pkg.sv ----
// types shared by the channel clash monitor
package clash_pkg;

  // fault state of the monitor
  typedef enum logic [0:0] {
    st_run_type_e   = 1'b0,
    st_fault_type_e = 1'b1
  } mon_state_type;

endpackage

// ---- field_load_switches.sv ----
// load switch model driving the field terminals
`timescale 1ns/1ps
module field_load_switches (
  // commanded lamps
  input  wire logic [15:0] cmd_green,
  input  wire logic [15:0] cmd_yellow,
  // field terminal levels
  output logic      [15:0] green_in,
  output logic      [15:0] yellow_in,
  output logic      [15:0] red_in
);
  // ======
  // red lit whenever neither green nor yellow is, so three inputs per channel
  assign green_in  = cmd_green;
  assign yellow_in = cmd_yellow;
  assign red_in    = ~(cmd_green | cmd_yellow);
endmodule

// ---- pair_clash_detect.sv ----
// combinational-to-registered clash detection over all channel pairs
`timescale 1ns/1ps
`include "clash_consts.svh"

module pair_clash_detect #(
  parameter int NUM_CH = `CLASH_NUM_CH
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // per channel active go indication (green or yellow)
  input  wire logic [NUM_CH-1:0]        go_active,
  // compatibility matrix, bit [i*NUM_CH+j] set means i and j may run together
  input  wire logic [NUM_CH*NUM_CH-1:0] compat_map,
  // registered clash result and offending channels
  output logic                          clash_q,
  output logic [NUM_CH-1:0]             clash_ch_q
);

  // =========================================================
  // pair check
  // =========================================================
  // a pair is permitted only if either direction of the map says so,
  // so a half-filled map never creates a spurious clash
  function automatic logic pair_ok(input logic [NUM_CH*NUM_CH-1:0] m,
                                   input int a, input int b);
    pair_ok = m[a*NUM_CH+b] | m[b*NUM_CH+a];
  endfunction

  logic [NUM_CH-1:0] ch_d;

  // every unmarked pair of simultaneously active channels is a clash
  always_comb begin
    ch_d = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      for (int j = 0; j < NUM_CH; j++) begin
        if (i != j && go_active[i] && go_active[j] && !pair_ok(compat_map, i, j)) begin
          ch_d[i] = 1'b1;
        end
      end
    end
  end

  // register the result to break the long pair tree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clash_q    <= 1'b0;
      clash_ch_q <= '0;
    end else begin
      clash_q    <= |ch_d;
      clash_ch_q <= ch_d;
    end
  end

endmodule

// ---- signal_channel_clash_monitor.sv ----
// top of the sixteen channel clash monitor
`timescale 1ns/1ps
`include "clash_consts.svh"

module signal_channel_clash_monitor #(
  parameter int NUM_CH     = `CLASH_NUM_CH,
  parameter int TICK_DIV   = `CLASH_TICK_DIV,
  parameter int QUAL_TICKS = `CLASH_QUAL_MS
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // field indications, asynchronous to ref_clk
  input  wire logic [NUM_CH-1:0]        green_in,
  input  wire logic [NUM_CH-1:0]        yellow_in,
  input  wire logic [NUM_CH-1:0]        red_in,
  // compatibility map, static configuration
  input  wire logic [NUM_CH*NUM_CH-1:0] compat_map,
  // clear requests, asynchronous levels, active low
  input  wire logic                     panel_reset_n,
  input  wire logic                     ext_reset_n,
  // fault outputs
  output logic                          clash_fault_q,
  output logic                          relay_ok_q,
  output logic                          halt_req_q,
  output logic [NUM_CH-1:0]             fault_ch_q
);

  // =========================================================
  // input synchronisers
  // =========================================================
  logic [NUM_CH-1:0] grn_s1_q, grn_s2_q;
  logic [NUM_CH-1:0] yel_s1_q, yel_s2_q;
  logic [NUM_CH-1:0] red_s1_q, red_s2_q;
  logic [1:0]        clr_s1_q, clr_s2_q;

  // three separate indications per channel, two flops each
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      grn_s1_q <= '0;
      grn_s2_q <= '0;
      yel_s1_q <= '0;
      yel_s2_q <= '0;
      red_s1_q <= '0;
      red_s2_q <= '0;
    end else begin
      grn_s1_q <= green_in;
      grn_s2_q <= grn_s1_q;
      yel_s1_q <= yellow_in;
      yel_s2_q <= yel_s1_q;
      red_s1_q <= red_in;
      red_s2_q <= red_s1_q;
    end
  end

  // clear buttons synchronised; reset state is "not pressed"
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clr_s1_q <= 2'b11;
      clr_s2_q <= 2'b11;
    end else begin
      clr_s1_q <= {panel_reset_n, ext_reset_n};
      clr_s2_q <= clr_s1_q;
    end
  end

  // red is sampled for completeness; clash looks only at go indications
  logic [NUM_CH-1:0] go_active;
  assign go_active = grn_s2_q | yel_s2_q;

  // =========================================================
  // pair detection
  // =========================================================
  logic              clash_now;
  logic [NUM_CH-1:0] clash_ch;

  pair_clash_detect #(
    .NUM_CH (NUM_CH)
  ) u_detect (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .go_active  (go_active),
    .compat_map (compat_map),
    .clash_q    (clash_now),
    .clash_ch_q (clash_ch)
  );

  // =========================================================
  // millisecond tick
  // =========================================================
  logic [17:0] div_q;
  logic        tick_q;

  // one shared timebase; per-channel timers would hang off the same tick
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_q  <= `CLASH_DIV_RST;
      tick_q <= 1'b0;
    end else if (div_q == 18'(TICK_DIV - 1)) begin
      div_q  <= `CLASH_DIV_RST;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 18'h0_0001;
      tick_q <= 1'b0;
    end
  end

  // =========================================================
  // recognition timer (single, shared over all channels)
  // =========================================================
  logic [15:0] persist_q;
  logic        qualified;

  // any break in the clash restarts the count, so only continuous
  // presence qualifies; the tick phase costs at most one ms of slack
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      persist_q <= `CLASH_CNT_RST;
    end else if (!clash_now) begin
      persist_q <= `CLASH_CNT_RST;
    end else if (tick_q && !qualified) begin
      persist_q <= persist_q + 16'h0001;
    end
  end

  // threshold between the 200 ms floor and 500 ms ceiling
  assign qualified = (persist_q >= 16'(QUAL_TICKS));

  // =========================================================
  // fault latch and outputs
  // =========================================================
  clash_pkg::mon_state_type state_q;
  logic                     clear_req;

  assign clear_req = !clr_s2_q[1] || !clr_s2_q[0];

  // fault set wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= clash_pkg::st_run_type_e;
    end else begin
      case (state_q)
        clash_pkg::st_run_type_e: begin
          if (clash_now && qualified) begin
            state_q <= clash_pkg::st_fault_type_e;
          end
        end
        clash_pkg::st_fault_type_e: begin
          if (clear_req && !(clash_now && qualified)) begin
            state_q <= clash_pkg::st_run_type_e;
          end                                       // else holds
        end
        default: state_q <= clash_pkg::st_run_type_e;
      endcase
    end
  end

  // relay de-energised and halt request in fault; channels captured at trip
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clash_fault_q <= 1'b0;
      relay_ok_q    <= 1'b0;
      halt_req_q    <= 1'b0;
      fault_ch_q    <= '0;
    end else begin
      clash_fault_q <= (state_q == clash_pkg::st_fault_type_e);
      relay_ok_q    <= (state_q == clash_pkg::st_run_type_e);
      halt_req_q    <= (state_q == clash_pkg::st_fault_type_e);
      // only updated outside fault, so the channel word drops on the same edge as the fault flag
      if (state_q == clash_pkg::st_run_type_e) begin
        fault_ch_q <= (clash_now && qualified) ? clash_ch : '0;
      end
    end
  end

endmodule

// ---- signal_channel_clash_monitor_bench.sv ----
// self-checking bench for the channel clash monitor
`timescale 1ns/1ps
module signal_channel_clash_monitor_bench;
  // ======
  // set up
  localparam int TD = 10;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
  logic         ref_clk = 1'b0, rstn = 1'b0, panel_reset_n = 1'b1, ext_reset_n = 1'b1;
  logic [15:0]  cmd_green = 16'h0000, cmd_yellow = 16'h0000, green_in, yellow_in, red_in, fault_ch_q;
  logic [255:0] compat_map = 256'h0;
  logic         clash_fault_q, relay_ok_q, halt_req_q;
  int           err_count = 0, checks_done = 0;
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  field_load_switches i_loads (.cmd_green(cmd_green), .cmd_yellow(cmd_yellow), .green_in(green_in),
    .yellow_in(yellow_in), .red_in(red_in));
  signal_channel_clash_monitor #(.NUM_CH(16), .TICK_DIV(TD), .QUAL_TICKS(350)) i_dut (.ref_clk(ref_clk),
    .rstn(rstn), .green_in(green_in), .yellow_in(yellow_in), .red_in(red_in), .compat_map(compat_map),
    .panel_reset_n(panel_reset_n), .ext_reset_n(ext_reset_n), .clash_fault_q(clash_fault_q),
    .relay_ok_q(relay_ok_q), .halt_req_q(halt_req_q), .fault_ch_q(fault_ch_q));
  // ======
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // two short runs split by a gap: together past threshold, never continuous
  task automatic t_short();
    cmd_green = 16'h0003;
    step(190 * TD);
    cmd_green = 16'h0001;
    step(3);
    cmd_green = 16'h0003;
    step(190 * TD);
    cmd_green = 16'h0000;
    step(20);
    `CHK("fault after short", 1'b0, clash_fault_q)
  endtask
  // permitted pair held long, one direction of the map only
  task automatic t_compat();
    compat_map[35] = 1'b1;
    cmd_green = 16'h0004;
    cmd_yellow = 16'h0008;
    step(600 * TD);
    cmd_green = 16'h0000;
    cmd_yellow = 16'h0000;
    `CHK("fault on permitted", 1'b0, clash_fault_q)
  endtask
  // trip, hold after removal, then clear through one of the two clears
  task automatic t_trip(input logic [15:0] g, input logic [15:0] y, input logic [15:0] ch, input bit panel);
    int n;
    n = 0;
    cmd_green = g;
    cmd_yellow = y;
    while (clash_fault_q !== 1'b1 && n < 600 * TD) begin
      step(1);
      n++;
    end
    if (n >= 600 * TD) begin
      err_count++;
      results();
    end
    `CHK("trip late", 1'b1, n <= 500 * TD)
    `CHK("trip early", 1'b1, n >= 200 * TD)
    `CHK("halt", 1'b1, halt_req_q)
    `CHK("relay", 1'b0, relay_ok_q)
    `CHK("channels", ch, fault_ch_q)
    step(40);
    `CHK("held while clash lasts", 1'b1, clash_fault_q)
    cmd_green = 16'h0000;
    cmd_yellow = 16'h0000;
    step(100);
    `CHK("latched", 1'b1, clash_fault_q)
    if (panel) panel_reset_n = 1'b0;
    else ext_reset_n = 1'b0;
    step(10);
    panel_reset_n = 1'b1;
    ext_reset_n = 1'b1;
    step(2);
    `CHK("cleared", 1'b0, clash_fault_q)
    `CHK("relay back", 1'b1, relay_ok_q)
    `CHK("channels cleared", 16'h0000, fault_ch_q)
  endtask
  // ======
  // main sequence
  initial begin
    step(8);
    rstn = 1'b1;
    step(4);
    t_short();
    t_compat();
    t_trip(16'h0010, 16'h0020, 16'h0030, 1'b1);
    t_trip(16'h8001, 16'h0000, 16'h8001, 1'b0);
    results();
  end
endmodule
